// [logic/nph_pkg.sv]
package nph_pkg;
    // ----------------------------------------------------------------
    // Metadata header layout
    // ----------------------------------------------------------------
    localparam logic [3:0] HDR_BYTES_FULL = 4'd12;
    localparam logic [3:0] HDR_BYTES_SHORT = 4'd10;
    localparam logic [3:0] HDR_FLAGS_POS = 4'd0;
    localparam logic [3:0] HDR_SEGTYPE_POS = 4'd1;
    localparam logic [3:0] HDR_HLEN_POS = 4'd2;
    localparam logic [3:0] HDR_SEGSZ_POS = 4'd4;
    localparam logic [3:0] HDR_CSTART_POS = 4'd6;
    localparam logic [3:0] HDR_COFF_POS = 4'd8;
    localparam logic [3:0] HDR_NBUF_POS = 4'd10;
    localparam int FLAG_NEEDS_CSUM_BIT = 0;
    localparam logic [7:0] SEG_KIND_NONE = 8'h00;
    localparam logic [7:0] SEG_KIND_TCP_IPV4 = 8'h01;
    localparam logic [7:0] SEG_KIND_UDP = 8'h03;
    localparam logic [7:0] SEG_KIND_TCP_IPV6 = 8'h04;
    localparam logic [7:0] SEG_ECN_MARKER = 8'h80;
    // ----------------------------------------------------------------
    // Size limits
    // ----------------------------------------------------------------
    localparam logic [16:0] PLAIN_FRAME_MAX = 17'd1514;
    localparam logic [16:0] RX_SEG_FRAME_MAX = 17'd65550;
    // ----------------------------------------------------------------
    // Register map and control fields
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_LAST_HDR = 12'h008;
    localparam logic [11:0] REG_COUNT = 12'h00c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_LEGACY = 0;
    localparam int CTRL_BIG_ENDIAN = 1;
    localparam int CTRL_MERGED_RX = 2;
    localparam int CTRL_CSUM = 3;
    localparam int CTRL_TX_TCP4 = 4;
    localparam int CTRL_TX_TCP6 = 5;
    localparam int CTRL_TX_UDP = 6;
    localparam int CTRL_TX_ECN = 7;
    localparam int CTRL_RX_TCP4 = 8;
    localparam int CTRL_RX_TCP6 = 9;
    localparam int CTRL_RX_UDP = 10;
    localparam int CTRL_WIDTH = 11;
endpackage : nph_pkg

// [logic/nph_csum.sv]
`timescale 1ns/1ps
`default_nettype none
// Running 16-bit ones' complement sum fed one byte per cycle.
module nph_csum (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic add_en,
    input wire logic high_byte,
    input wire logic [7:0] data,
    output logic [15:0] sum
);
    logic [15:0] next_sum;
    logic [16:0] wide;

    always_comb begin
        wide = {1'b0, sum} + (high_byte ? {1'b0, data, 8'h00} : {9'h000, data});
        next_sum = sum;
        if (clear) begin
            next_sum = 16'h0000;
        end else if (add_en) begin
            // End-around carry keeps the sum in ones' complement form.
            next_sum = wide[15:0] + {15'h0000, wide[16]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum <= 16'h0000;
        end else begin
            sum <= next_sum;
        end
    end
endmodule : nph_csum
`default_nettype wire

// [logic/nph_offload.sv]
// Summary of operation
// - Twelve-byte header, fields in fixed order.
// - Flag bit value one means checksum incomplete.
// - Segment kinds 0,1,3,4 plus ECN marker.
// - Legacy mode uses guest native byte order.
// - Legacy without merged buffers drops count field.
// - Device sums from start, stores at offset.
// - Segmentation cuts large packets, replicates header.
// - Device ignores unknown flag bits.
// - Clear flag: checksum fields unused, untrusted.
// - Header length is only a hint.
// - Receive limit 65550 with offloads, else 1514.
// - Without merging, buffer count is one.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module nph_offload #(
    parameter int MEM_DEPTH = 4096
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_last,
    output logic tx_in_ready,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    output logic tx_out_last,
    input wire logic tx_out_ready,
    output logic tx_used,
    input wire logic rx_req,
    input wire logic [16:0] rx_len,
    input wire logic [15:0] rx_num_buffers,
    output logic rx_ready,
    output logic rx_hdr_valid,
    output logic [7:0] rx_hdr_data,
    output logic rx_hdr_last,
    input wire logic rx_hdr_ready,
    output logic rx_drop
);
    localparam int AW = $clog2(MEM_DEPTH);

    typedef enum logic [3:0] {
        TX_HDR = 4'b0001,
        TX_LOAD = 4'b0010,
        TX_FIX = 4'b0100,
        TX_EMIT = 4'b1000
    } nph_tx_state_t;

    // Picks byte 0 or 1 of a 16-bit field as laid out in memory.
    function automatic logic [7:0] nph_field_byte(input logic [15:0] v, input logic idx, input logic big);
        nph_field_byte = (idx ^ big) ? v[15:8] : v[7:0];
    endfunction : nph_field_byte

    function automatic logic [15:0] nph_field(input logic [7:0] b0, input logic [7:0] b1, input logic big);
        nph_field = big ? {b0, b1} : {b1, b0};
    endfunction : nph_field

    // ----------------------------------------------------------------
    // Control register and derived modes
    // ----------------------------------------------------------------
    logic [nph_pkg::CTRL_WIDTH-1:0] ctrl;
    logic big_order;
    logic short_hdr;
    logic [3:0] hdr_bytes;
    logic rx_seg_feat;

    assign big_order = ctrl[nph_pkg::CTRL_LEGACY] & ctrl[nph_pkg::CTRL_BIG_ENDIAN];
    assign short_hdr = ctrl[nph_pkg::CTRL_LEGACY] & ~ctrl[nph_pkg::CTRL_MERGED_RX];
    assign hdr_bytes = short_hdr ? nph_pkg::HDR_BYTES_SHORT : nph_pkg::HDR_BYTES_FULL;
    assign rx_seg_feat = ctrl[nph_pkg::CTRL_RX_TCP4] | ctrl[nph_pkg::CTRL_RX_TCP6] | ctrl[nph_pkg::CTRL_RX_UDP];

    // ----------------------------------------------------------------
    // Transmit path state
    // ----------------------------------------------------------------
    logic [7:0] hdr [0:11];
    logic [7:0] mem [0:MEM_DEPTH-1];
    nph_tx_state_t state, next_state;
    logic [3:0] hcnt, next_hcnt;
    logic [15:0] wcnt, next_wcnt;
    logic [15:0] pay_ptr, next_pay_ptr;
    logic [15:0] rep_idx, next_rep_idx;
    logic [15:0] seg_cnt, next_seg_cnt;
    logic hphase, next_hphase;
    logic overflow, next_overflow;
    logic next_tx_out_valid, next_tx_out_last, next_tx_used;
    logic [7:0] next_tx_out_data;
    logic [15:0] pkt_count, next_pkt_count;
    logic [15:0] seg_total, next_seg_total;

    logic [7:0] flags, seg_type, seg_base;
    logic [15:0] hlen, seg_size, cstart, coff, cpos;
    logic needs_csum, seg_feat_ok, seg_en;
    logic [15:0] rep_len, mss;
    logic take_in, out_free, mem_we, fix_we;
    logic [15:0] csum_sum;
    logic [15:0] rel;
    logic [7:0] emit_byte;
    logic emit_seg_end, emit_pkt_end;

    assign flags = hdr[nph_pkg::HDR_FLAGS_POS];
    assign seg_type = hdr[nph_pkg::HDR_SEGTYPE_POS];
    assign seg_base = seg_type & ~nph_pkg::SEG_ECN_MARKER;
    assign hlen = nph_field(hdr[nph_pkg::HDR_HLEN_POS], hdr[nph_pkg::HDR_HLEN_POS + 4'd1], big_order);
    assign seg_size = nph_field(hdr[nph_pkg::HDR_SEGSZ_POS], hdr[nph_pkg::HDR_SEGSZ_POS + 4'd1], big_order);
    assign cstart = nph_field(hdr[nph_pkg::HDR_CSTART_POS], hdr[nph_pkg::HDR_CSTART_POS + 4'd1], big_order);
    assign coff = nph_field(hdr[nph_pkg::HDR_COFF_POS], hdr[nph_pkg::HDR_COFF_POS + 4'd1], big_order);
    assign cpos = cstart + coff;
    // Only the needs-checksum bit is acted on; other flag bits are ignored.
    assign needs_csum = flags[nph_pkg::FLAG_NEEDS_CSUM_BIT] & ctrl[nph_pkg::CTRL_CSUM];
    assign seg_feat_ok = (seg_base == nph_pkg::SEG_KIND_TCP_IPV4 && ctrl[nph_pkg::CTRL_TX_TCP4])
        || (seg_base == nph_pkg::SEG_KIND_TCP_IPV6 && ctrl[nph_pkg::CTRL_TX_TCP6])
        || (seg_base == nph_pkg::SEG_KIND_UDP && ctrl[nph_pkg::CTRL_TX_UDP]);
    // A header length not below the packet length turns segmentation off, so a bad value cannot stall it.
    assign seg_en = seg_feat_ok && ({1'b0, wcnt} > nph_pkg::PLAIN_FRAME_MAX) && (hlen < wcnt);
    assign rep_len = seg_en ? hlen : 16'h0000;
    assign mss = (seg_en && seg_size != 16'h0000) ? seg_size : wcnt;

    assign out_free = ~tx_out_valid | tx_out_ready;
    assign take_in = tx_in_valid & tx_in_ready;
    assign mem_we = take_in && state == TX_LOAD && wcnt < 16'(MEM_DEPTH);
    assign rel = wcnt - cstart;
    // Clear flag: sum and patch are both skipped, whatever the packet holds.
    assign fix_we = state == TX_FIX && needs_csum && !overflow && (cpos + 16'h0001) < wcnt;

    nph_csum u_csum (
        .pclk(pclk),
        .presetn(presetn),
        .clear(state == TX_HDR),
        .add_en(mem_we && needs_csum && wcnt >= cstart),
        .high_byte(~rel[0]),
        .data(tx_in_data),
        .sum(csum_sum)
    );

    assign emit_byte = hphase ? mem[rep_idx[AW-1:0]] : mem[pay_ptr[AW-1:0]];
    assign emit_pkt_end = !hphase && pay_ptr + 16'h0001 >= wcnt;
    assign emit_seg_end = !hphase && (emit_pkt_end || seg_cnt + 16'h0001 >= mss);

    always_comb begin
        next_state = state;
        next_hcnt = hcnt;
        next_wcnt = wcnt;
        next_pay_ptr = pay_ptr;
        next_rep_idx = rep_idx;
        next_seg_cnt = seg_cnt;
        next_hphase = hphase;
        next_overflow = overflow;
        next_tx_out_valid = tx_out_valid & ~tx_out_ready;
        next_tx_out_data = tx_out_data;
        next_tx_out_last = tx_out_last;
        next_tx_used = 1'b0;
        next_pkt_count = pkt_count;
        next_seg_total = seg_total;
        case (state)
            TX_HDR: begin
                if (take_in) begin
                    next_hcnt = hcnt + 4'd1;
                    if (hcnt + 4'd1 == hdr_bytes) begin
                        next_state = TX_LOAD;
                        next_wcnt = 16'h0000;
                        next_overflow = 1'b0;
                    end
                end
            end
            TX_LOAD: begin
                if (take_in) begin
                    if (wcnt < 16'(MEM_DEPTH)) begin
                        next_wcnt = wcnt + 16'h0001;
                    end else begin
                        next_overflow = 1'b1;
                    end
                    if (tx_in_last) begin
                        next_state = TX_FIX;
                    end
                end
            end
            TX_FIX: begin
                next_state = TX_EMIT;
                next_pay_ptr = 16'h0000;
                next_rep_idx = 16'h0000;
                next_seg_cnt = 16'h0000;
                next_hphase = 1'b0;
                if (seg_en) begin
                    next_hphase = 1'b1;
                    next_pay_ptr = hlen;
                end
                if (wcnt == 16'h0000) begin
                    next_state = TX_HDR;
                    next_hcnt = 4'd0;
                    next_tx_used = 1'b1;
                end
            end
            TX_EMIT: begin
                if (out_free) begin
                    next_tx_out_valid = 1'b1;
                    next_tx_out_data = emit_byte;
                    next_tx_out_last = emit_seg_end;
                    if (hphase) begin
                        next_rep_idx = rep_idx + 16'h0001;
                        if (rep_idx + 16'h0001 >= rep_len) begin
                            next_hphase = 1'b0;
                        end
                    end else begin
                        next_pay_ptr = pay_ptr + 16'h0001;
                        next_seg_cnt = seg_cnt + 16'h0001;
                        if (emit_seg_end) begin
                            next_seg_total = seg_total + 16'h0001;
                            next_seg_cnt = 16'h0000;
                            next_rep_idx = 16'h0000;
                            next_hphase = rep_len != 16'h0000;
                        end
                        if (emit_pkt_end) begin
                            next_state = TX_HDR;
                            next_hcnt = 4'd0;
                            next_hphase = 1'b0;
                            next_tx_used = 1'b1;
                            next_pkt_count = pkt_count + 16'h0001;
                        end
                    end
                end
            end
            default: begin
                next_state = TX_HDR;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= TX_HDR;
            hcnt <= 4'd0;
            wcnt <= 16'h0000;
            pay_ptr <= 16'h0000;
            rep_idx <= 16'h0000;
            seg_cnt <= 16'h0000;
            hphase <= 1'b0;
            overflow <= 1'b0;
            tx_out_valid <= 1'b0;
            tx_out_data <= 8'h00;
            tx_out_last <= 1'b0;
            tx_used <= 1'b0;
            tx_in_ready <= 1'b0;
            pkt_count <= 16'h0000;
            seg_total <= 16'h0000;
        end else begin
            state <= next_state;
            hcnt <= next_hcnt;
            wcnt <= next_wcnt;
            pay_ptr <= next_pay_ptr;
            rep_idx <= next_rep_idx;
            seg_cnt <= next_seg_cnt;
            hphase <= next_hphase;
            overflow <= next_overflow;
            tx_out_valid <= next_tx_out_valid;
            tx_out_data <= next_tx_out_data;
            tx_out_last <= next_tx_out_last;
            tx_used <= next_tx_used;
            tx_in_ready <= (next_state == TX_HDR || next_state == TX_LOAD) && !(take_in && tx_in_last);
            pkt_count <= next_pkt_count;
            seg_total <= next_seg_total;
        end
    end

    // Header and packet storage carry no reset, as plain memory would not.
    always_ff @(posedge pclk) begin
        if (take_in && state == TX_HDR) begin
            hdr[hcnt] <= tx_in_data;
        end
        if (mem_we) begin
            mem[wcnt[AW-1:0]] <= tx_in_data;
        end
        if (fix_we) begin
            // Network order: the high byte of the checksum goes first.
            mem[cpos[AW-1:0]] <= ~csum_sum[15:8];
            mem[cpos[AW-1:0] + AW'(1)] <= ~csum_sum[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Receive header generator
    // ----------------------------------------------------------------
    logic rx_busy, next_rx_busy;
    logic [3:0] rx_idx, next_rx_idx;
    logic [15:0] rx_nbuf, next_rx_nbuf;
    logic next_rx_hdr_valid, next_rx_hdr_last, next_rx_drop;
    logic [7:0] next_rx_hdr_data, rx_byte;
    logic [16:0] rx_limit;
    logic [15:0] drop_count, next_drop_count;

    assign rx_limit = rx_seg_feat ? nph_pkg::RX_SEG_FRAME_MAX : nph_pkg::PLAIN_FRAME_MAX;

    // Flags, segment type and offload fields are sent as zero: the packet goes out fully formed.
    always_comb begin
        rx_byte = 8'h00;
        if (rx_idx >= nph_pkg::HDR_NBUF_POS) begin
            rx_byte = nph_field_byte(rx_nbuf, rx_idx[0], big_order);
        end
    end

    always_comb begin
        next_rx_busy = rx_busy;
        next_rx_idx = rx_idx;
        next_rx_nbuf = rx_nbuf;
        next_rx_hdr_valid = rx_hdr_valid & ~rx_hdr_ready;
        next_rx_hdr_data = rx_hdr_data;
        next_rx_hdr_last = rx_hdr_last;
        next_rx_drop = 1'b0;
        next_drop_count = drop_count;
        if (!rx_busy) begin
            if (rx_req && rx_ready) begin
                if (rx_len > rx_limit) begin
                    next_rx_drop = 1'b1;
                    next_drop_count = drop_count + 16'h0001;
                end else begin
                    next_rx_busy = 1'b1;
                    next_rx_idx = 4'd0;
                    next_rx_nbuf = 16'h0001;
                    if (ctrl[nph_pkg::CTRL_MERGED_RX] && rx_num_buffers != 16'h0000) begin
                        next_rx_nbuf = rx_num_buffers;
                    end
                end
            end
        end else if (!rx_hdr_valid || rx_hdr_ready) begin
            next_rx_hdr_valid = 1'b1;
            next_rx_hdr_data = rx_byte;
            next_rx_hdr_last = rx_idx + 4'd1 == hdr_bytes;
            next_rx_idx = rx_idx + 4'd1;
            if (rx_idx + 4'd1 == hdr_bytes) begin
                next_rx_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy <= 1'b0;
            rx_idx <= 4'd0;
            rx_nbuf <= 16'h0000;
            rx_hdr_valid <= 1'b0;
            rx_hdr_data <= 8'h00;
            rx_hdr_last <= 1'b0;
            rx_drop <= 1'b0;
            rx_ready <= 1'b0;
            drop_count <= 16'h0000;
        end else begin
            rx_busy <= next_rx_busy;
            rx_idx <= next_rx_idx;
            rx_nbuf <= next_rx_nbuf;
            rx_hdr_valid <= next_rx_hdr_valid;
            rx_hdr_data <= next_rx_hdr_data;
            rx_hdr_last <= next_rx_hdr_last;
            rx_drop <= next_rx_drop;
            rx_ready <= ~next_rx_busy & ~(rx_req & rx_ready & ~rx_busy);
            drop_count <= next_drop_count;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic [nph_pkg::CTRL_WIDTH-1:0] next_ctrl;
    logic next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic apb_req, apb_done;

    assign apb_req = psel & penable & ~pready;
    assign apb_done = psel & penable & pready;

    always_comb begin
        next_ctrl = ctrl;
        next_pready = apb_req;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (apb_req) begin
            next_prdata = 32'h0000_0000;
            if (paddr == nph_pkg::REG_CTRL) begin
                next_prdata = 32'(ctrl);
            end else if (paddr == nph_pkg::REG_STATUS) begin
                next_prdata = {23'h000000, overflow, rx_busy, state, short_hdr, big_order, needs_csum};
            end else if (paddr == nph_pkg::REG_LAST_HDR) begin
                next_prdata = {seg_size, seg_type, flags};
            end else if (paddr == nph_pkg::REG_COUNT) begin
                next_prdata = {drop_count[7:0], seg_total[7:0], pkt_count};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (apb_done && pwrite && !pslverr && paddr == nph_pkg::REG_CTRL) begin
            next_ctrl = pwdata[nph_pkg::CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= nph_pkg::CTRL_RESET[nph_pkg::CTRL_WIDTH-1:0];
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end
endmodule : nph_offload
`default_nettype wire

// [bench/nph_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module nph_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_in_valid,
    input wire logic tx_in_last,
    input wire logic tx_in_ready,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_last,
    input wire logic tx_out_ready,
    input wire logic tx_used,
    input wire logic rx_req,
    input wire logic [16:0] rx_len,
    input wire logic rx_ready,
    input wire logic rx_hdr_valid,
    input wire logic [7:0] rx_hdr_data,
    input wire logic rx_hdr_ready,
    input wire logic rx_drop
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rx_take;
        rx_req && rx_ready;
    endsequence
    sequence s_tx_end;
        tx_in_valid && tx_in_ready && tx_in_last;
    endsequence
    AST_RX_BIG: assert property (s_rx_take ##0 (rx_len > 17'd65550) |=> rx_drop)
        else $error("oversize kept");
    AST_RX_SMALL: assert property (s_rx_take ##0 (rx_len <= 17'd1514) |=> !rx_drop ##1 rx_hdr_valid)
        else $error("plain receive lost");
    AST_DROP_NO_HDR: assert property (rx_drop |-> !rx_hdr_valid)
        else $error("header on drop");
    AST_RX_HOLD: assert property (rx_hdr_valid && !rx_hdr_ready |=> rx_hdr_valid && $stable(rx_hdr_data))
        else $error("header byte moved");
    AST_TX_HOLD: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data))
        else $error("output byte moved");
    AST_TX_IN_STOP: assert property (s_tx_end |=> !tx_in_ready)
        else $error("input open after end");
    AST_USED_PULSE: assert property (tx_used |=> !tx_used)
        else $error("used too long");
    AST_USED_LAST: assert property (tx_used |-> tx_out_valid && tx_out_last)
        else $error("used before last");
endmodule : nph_sva
`default_nettype wire

// [bench/nph_guest.sv]
`timescale 1ns/1ps
`default_nettype none
module nph_guest (
    input wire logic pclk,
    output logic tx_in_valid,
    output logic [7:0] tx_in_data,
    output logic tx_in_last,
    input wire logic tx_in_ready,
    input wire logic tx_out_valid,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_last,
    output logic tx_out_ready,
    input wire logic tx_used,
    input wire logic rx_hdr_valid,
    input wire logic [7:0] rx_hdr_data,
    input wire logic rx_hdr_last,
    output logic rx_hdr_ready
);
    logic [8:0] got[$];
    logic [8:0] rxg[$];
    int nused = 0;
    initial begin
        tx_in_valid = 1'b0;
        tx_in_data = 8'h00;
        tx_in_last = 1'b0;
    end
    // Random stalls keep both sinks from always being ready.
    always @(posedge pclk) begin
        if (tx_out_valid && tx_out_ready) got.push_back({tx_out_last, tx_out_data});
        if (rx_hdr_valid && rx_hdr_ready) rxg.push_back({rx_hdr_last, rx_hdr_data});
        if (tx_used) nused++;
        tx_out_ready <= ($urandom % 4) != 0;
        rx_hdr_ready <= 1'($urandom);
    end
    task automatic send(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            tx_in_valid <= 1'b1;
            tx_in_data <= b[i];
            tx_in_last <= i == b.size() - 1;
            do @(posedge pclk); while (!tx_in_ready);
        end
        tx_in_valid <= 1'b0;
        tx_in_last <= 1'b0;
        tx_in_data <= ~b[b.size() - 1];
    endtask : send
endmodule : nph_guest
`default_nettype wire

// [bench/net_packet_header_offload_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module net_packet_header_offload_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_req = 0, pready, pslverr, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic tx_in_valid, tx_in_last, tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready, tx_used;
    logic rx_ready, rx_hdr_valid, rx_hdr_last, rx_hdr_ready, rx_drop;
    logic [7:0] tx_in_data, tx_out_data, rx_hdr_data;
    logic [16:0] rx_len = 0;
    logic [15:0] rx_num_buffers = 0;
    logic [7:0] pk[$];
    logic [8:0] ex[$];
    int err_count = 0, comparisons = 0, cyc = 0, nexp = 0;
    nph_offload #(.MEM_DEPTH(2048)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tx_in_valid, .tx_in_data, .tx_in_last, .tx_in_ready, .tx_out_valid, .tx_out_data,
        .tx_out_last, .tx_out_ready, .tx_used, .rx_req, .rx_len, .rx_num_buffers, .rx_ready, .rx_hdr_valid,
        .rx_hdr_data, .rx_hdr_last, .rx_hdr_ready, .rx_drop);
    nph_guest gst (.pclk, .tx_in_valid, .tx_in_data, .tx_in_last, .tx_in_ready, .tx_out_valid, .tx_out_data,
        .tx_out_last, .tx_out_ready, .tx_used, .rx_hdr_valid, .rx_hdr_data, .rx_hdr_last, .rx_hdr_ready);
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic cmp(ref logic [8:0] g[$]);
        for (int w = 0; w < 6000 && g.size() < ex.size(); w++) @(posedge pclk);
        chk(g.size(), ex.size());
        foreach (ex[i]) chk(g[i], ex[i]);
    endtask : cmp
    task automatic rx(input logic [16:0] len, input logic [15:0] nb, input int n, input logic [15:0] c, input logic be);
        ex = {};
        for (int i = 0; i < n; i++) ex.push_back({i == n - 1, 8'h00});
        if (n == 12) begin
            ex[10][7:0] = be ? c[15:8] : c[7:0];
            ex[11][7:0] = be ? c[7:0] : c[15:8];
        end
        gst.rxg = {};
        rx_req <= 1'b1;
        rx_len <= len;
        rx_num_buffers <= nb;
        do @(posedge pclk); while (!rx_ready);
        rx_req <= 1'b0;
        @(posedge pclk);
        chk(rx_drop, n == 0);
        cmp(gst.rxg);
    endtask : rx
    // The checksum is summed once from the checksum start to the packet end; segments reuse the patched header.
    task automatic tx(input logic [7:0] fl, st, input int cs, co, len, seg);
        logic [7:0] b[$];
        int s;
        pk = {};
        for (int i = 0; i < len; i++) pk.push_back(8'($urandom));
        b = {fl, st, 8'd54, 8'h00, 8'he8, 8'h03, cs[7:0], cs[15:8], co[7:0], co[15:8], 8'h00, 8'h00};
        b = {b, pk};
        s = 0;
        if (fl[0]) begin
            for (int i = cs; i < len; i++) s += (i - cs) % 2 ? pk[i] : {pk[i], 8'h00};
            s = (s & 16'hffff) + (s >> 16);
            s = ~((s & 16'hffff) + (s >> 16));
            pk[cs + co] = s[15:8];
            pk[cs + co + 1] = s[7:0];
        end
        ex = {};
        for (int p = seg ? 54 : 0; p < len; p += seg ? 1000 : len) begin
            for (int i = 0; i < (seg ? 54 : 0); i++) ex.push_back({1'b0, pk[i]});
            for (int i = p; i < len && i < p + (seg ? 1000 : len); i++) ex.push_back({1'b0, pk[i]});
            ex[ex.size() - 1][8] = 1'b1;
        end
        gst.send(b);
        cmp(gst.got);
        gst.got = {};
        nexp++;
        chk(gst.nused, nexp);
    endtask : tx
    initial begin
        void'($urandom(53));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, nph_pkg::REG_CTRL, 32'h0);
        rx(17'($urandom_range(1514, 1)), 16'h5, 12, 16'h1, 1'b0);
        rx(17'd1515, 16'h0, 0, 16'h0, 1'b0);
        for (int k = nph_pkg::CTRL_RX_TCP4; k <= nph_pkg::CTRL_RX_UDP; k++) begin
            apb(1'b1, nph_pkg::REG_CTRL, 32'h1 << k);
            rx(17'd65550, 16'h0, 12, 16'h1, 1'b0);
            rx(17'd65551, 16'h0, 0, 16'h0, 1'b0);
        end
        apb(1'b1, nph_pkg::REG_CTRL, 32'h1);
        rx(17'd60, 16'h0, 10, 16'h0, 1'b0);
        apb(1'b1, nph_pkg::REG_CTRL, 32'h7);
        apb(1'b0, nph_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h7);
        rx(17'd60, 16'h0203, 12, 16'h0203, 1'b1);
        apb(1'b1, nph_pkg::REG_CTRL, 32'h4);
        rx(17'd60, 16'h0203, 12, 16'h0203, 1'b0);
        tx(8'h00, 8'h00, 0, 0, 64, 0);
        apb(1'b1, nph_pkg::REG_CTRL, 32'h8);
        tx(8'h41, 8'h00, 14, 6, 64, 0);
        tx(8'h40, 8'h00, 20, 200, 64, 0);
        apb(1'b1, nph_pkg::REG_CTRL, 32'hf8);
        tx(8'h01, 8'h81, 34, 16, 1600, 1);
        tx(8'h01, 8'h03, 34, 16, 1600, 1);
        tx(8'h01, 8'h04, 34, 16, 1600, 1);
        end_of_test();
    end
endmodule : net_packet_header_offload_tb
bind nph_offload nph_sva u_sva (.pclk, .presetn, .tx_in_valid, .tx_in_last, .tx_in_ready, .tx_out_valid,
    .tx_out_data, .tx_out_last, .tx_out_ready, .tx_used, .rx_req, .rx_len, .rx_ready, .rx_hdr_valid,
    .rx_hdr_data, .rx_hdr_ready, .rx_drop);
`default_nettype wire
